// ---- tcsc_timer.sv ----
// Timer status/control, clock source selection, prescaler and 16-bit
// counter with coherent byte reads, behind an AXI4-Lite slave.
// Assumes fixed and external clock inputs are asynchronous levels and
// debug_active comes from logic on aclk.
//
// Notes on behaviour
// R01 - Up mode: overflow flag sets when counter wraps to zero after modulo.
// R02 - Center mode: flag sets on the step down after reaching modulo.
// R03 - Flag clears only by reading it set, then writing 0.
// R04 - Overflow between arming read and clearing write restarts the sequence.
// R05 - Writing 1 to the flag does nothing; reset clears it.
// R06 - Interrupt requested while flag and enable are both set.
// R07 - Center select 0 counts up; 1 counts up/down, channels center-aligned.
// R08 - Two-bit clock select: none, bus, fixed, external pin clock.
// R09 - Fixed and external clocks are synchronised to the bus clock.
// R10 - External clock supplier keeps it at most a quarter of bus clock.
// R11 - Software sets shared channel's edge/level bits to 0:0.
// R12 - Prescaler divides by two to the power of the three-bit field.
// R13 - Prescaler follows synchronisation and source selection.
// R14 - Reading a counter byte freezes both until the other is read.
// R15 - Latch released by reset, counter byte writes, status writes.
// R16 - Reset clears the counter and the status/control register.
// R17 - Any write to a counter byte resets the counter.
// R18 - Modulo 0x0000 or 0xFFFF gives free running over full range.
// R19 - Debug mode freezes counter and latch even when bytes are read.
// R20 - Interrupt request is a level following flag and enable.
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module tcsc_timer
    import tcsc_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire tcsc_axi_req_t axi_req,
    output tcsc_axi_rsp_t axi_rsp,
    // Clock source inputs
    input wire logic fixed_system_clock,
    input wire logic external_timer_clock,
    // Debug freeze
    input wire logic debug_active,
    // Channels and interrupt
    output tcsc_timebase_t timebase,
    output logic overflow_irq
);

    tcsc_state_t state_reg;
    tcsc_state_t state_next;

    function automatic tcsc_sel_t decode(input logic [7:0] addr);
        if (addr[7:2] == TCSC_OFF_SC[7:2]) begin
            return SEL_SC;
        end else if (addr[7:2] == TCSC_OFF_CNTH[7:2]) begin
            return SEL_CNTH;
        end else if (addr[7:2] == TCSC_OFF_CNTL[7:2]) begin
            return SEL_CNTL;
        end else if (addr[7:2] == TCSC_OFF_MOD[7:2]) begin
            return SEL_MOD;
        end else begin
            return SEL_NONE;
        end
    endfunction

    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_write;
    tcsc_sel_t wsel;
    tcsc_sel_t rsel;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic src_tick;
    logic [6:0] ps_mask;
    logic step;
    logic ovf_event;
    logic [15:0] top;
    logic wr_cnt;
    logic wr_sc;
    logic [15:0] cnt_view;

    always_comb begin
        state_next = state_reg;
        aw_hs = axi_req.awvalid && state_reg.wr == WR_IDLE
            && !state_reg.aw_got;
        w_hs = axi_req.wvalid && state_reg.wr == WR_IDLE && !state_reg.w_got;
        ar_hs = axi_req.arvalid && state_reg.rd == RD_IDLE;
        wa = state_reg.aw_got ? state_reg.awaddr : axi_req.awaddr;
        wd = state_reg.w_got ? state_reg.wdata : axi_req.wdata;
        ws = state_reg.w_got ? state_reg.wstrb : axi_req.wstrb;
        do_write = (state_reg.aw_got || aw_hs) && (state_reg.w_got || w_hs);
        wsel = decode(wa);
        rsel = decode(axi_req.araddr);
        wr_cnt = do_write && (wsel == SEL_CNTH || wsel == SEL_CNTL);
        wr_sc = do_write && wsel == SEL_SC && ws[0];

        // Write channel: address and data may arrive in either order
        if (aw_hs && !do_write) begin
            state_next.aw_got = 1'b1;
            state_next.awaddr = axi_req.awaddr;
        end
        if (w_hs && !do_write) begin
            state_next.w_got = 1'b1;
            state_next.wdata = axi_req.wdata;
            state_next.wstrb = axi_req.wstrb;
        end
        if (do_write) begin
            state_next.aw_got = 1'b0;
            state_next.w_got = 1'b0;
            state_next.wr = WR_RESP;
            state_next.bresp = (wsel == SEL_NONE) ? TCSC_RESP_SLVERR
                : TCSC_RESP_OKAY;
        end
        if (state_reg.wr == WR_RESP && axi_req.bready) begin
            state_next.wr = WR_IDLE;
        end

        // Two-flop synchronisers; edge detect reads only the second stage
        state_next.fix_sync = {state_reg.fix_sync[0], fixed_system_clock}; // [R09]
        state_next.ext_sync = {state_reg.ext_sync[0], external_timer_clock}; // [R09]
        state_next.fix_prev = state_reg.fix_sync[1];
        state_next.ext_prev = state_reg.ext_sync[1];

        case (state_reg.clk_sel) // [R08]
            TCSC_CS_BUS: src_tick = 1'b1;
            TCSC_CS_FIXED: src_tick = state_reg.fix_sync[1]
                && !state_reg.fix_prev;
            TCSC_CS_EXT: src_tick = state_reg.ext_sync[1]
                && !state_reg.ext_prev;
            default: src_tick = 1'b0;
        endcase

        // Prescaler after source selection; one step per 2**ps source ticks
        ps_mask = 7'((8'd1 << state_reg.ps) - 8'd1); // [R12] [R13]
        step = src_tick && !debug_active
            && ((state_reg.pre & ps_mask) == ps_mask); // [R19]
        if (src_tick && !debug_active) begin
            state_next.pre = state_reg.pre + 7'd1;
        end

        // Modulo of all zeros or all ones runs the full range
        top = (state_reg.modulo == TCSC_CNT_ZERO) ? TCSC_CNT_TOP
            : state_reg.modulo; // [R18]
        ovf_event = 1'b0;
        if (step) begin
            if (!state_reg.cas) begin // [R07]
                state_next.down = 1'b0;
                if (state_reg.count >= top) begin
                    state_next.count = TCSC_CNT_ZERO;
                    ovf_event = 1'b1; // [R01]
                end else begin
                    state_next.count = state_reg.count + 16'd1;
                end
            end else if (state_reg.down) begin // [R07]
                if (state_reg.count == TCSC_CNT_ZERO) begin
                    state_next.down = 1'b0;
                    state_next.count = 16'd1;
                end else begin
                    state_next.count = state_reg.count - 16'd1;
                end
            end else if (state_reg.count >= top) begin
                state_next.down = 1'b1;
                state_next.count = top - 16'd1;
                ovf_event = 1'b1; // [R02]
            end else begin
                state_next.count = state_reg.count + 16'd1;
            end
        end

        // Counter byte writes clear the count whatever the data
        if (wr_cnt) begin
            state_next.count = TCSC_CNT_RST; // [R17]
            state_next.down = 1'b0;
            state_next.pre = 7'd0;
            ovf_event = 1'b0;
        end

        if (do_write && wsel == SEL_MOD) begin
            if (ws[0]) begin
                state_next.modulo[7:0] = wd[7:0];
            end
            if (ws[1]) begin
                state_next.modulo[15:8] = wd[15:8];
            end
        end

        if (wr_sc) begin
            state_next.ovie = wd[TCSC_BIT_OVIE];
            state_next.cas = wd[TCSC_BIT_CAS];
            state_next.clk_sel = {wd[TCSC_BIT_CSHI], wd[TCSC_BIT_CSLO]};
            state_next.ps = wd[TCSC_PS_MSB:TCSC_PS_LSB];
            // Writing 1 leaves the flag alone
            if (state_reg.armed && !wd[TCSC_BIT_OVF]) begin // [R03] [R05]
                state_next.ovf = 1'b0;
            end
            state_next.armed = 1'b0;
        end

        // Read channel and its side effects
        if (ar_hs) begin
            state_next.rd = RD_DATA;
            state_next.rresp = TCSC_RESP_OKAY;
            state_next.rdata = 32'h0000_0000;
            cnt_view = state_reg.latched ? state_reg.hold : state_reg.count;
            if (rsel == SEL_SC) begin
                state_next.rdata[7:0] = {state_reg.ovf, state_reg.ovie,
                    state_reg.cas, state_reg.clk_sel, state_reg.ps};
                if (state_reg.ovf) begin
                    state_next.armed = 1'b1; // [R03]
                end
            end else if (rsel == SEL_CNTH || rsel == SEL_CNTL) begin
                state_next.rdata[7:0] = (rsel == SEL_CNTH) ? cnt_view[15:8]
                    : cnt_view[7:0];
                // Debug keeps the latch where it stood
                if (!debug_active) begin // [R19]
                    if (!state_reg.latched) begin
                        state_next.latched = 1'b1; // [R14]
                        state_next.hold = state_reg.count;
                        state_next.latch_hi = (rsel == SEL_CNTH);
                    end else if (state_reg.latch_hi != (rsel == SEL_CNTH)) begin
                        state_next.latched = 1'b0; // [R14]
                    end
                end
            end else if (rsel == SEL_MOD) begin
                state_next.rdata[15:0] = state_reg.modulo;
            end else begin
                state_next.rresp = TCSC_RESP_SLVERR;
            end
        end else begin
            cnt_view = state_reg.count;
        end
        if (state_reg.rd == RD_DATA && axi_req.rready) begin
            state_next.rd = RD_IDLE;
        end

        // A counter byte write or a status/control write ends any pending byte pairing
        if (wr_cnt || wr_sc) begin
            state_next.latched = 1'b0; // [R15]
        end

        // A new overflow wins over a clear and restarts the sequence
        if (ovf_event) begin
            state_next.ovf = 1'b1; // [R04]
            state_next.armed = 1'b0; // [R04]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0; // [R16] [R05] [R15]
            state_reg.wr <= WR_IDLE;
            state_reg.rd <= RD_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_comb begin
        axi_rsp.awready = state_reg.wr == WR_IDLE && !state_reg.aw_got;
        axi_rsp.wready = state_reg.wr == WR_IDLE && !state_reg.w_got;
        axi_rsp.bvalid = state_reg.wr == WR_RESP;
        axi_rsp.bresp = state_reg.bresp;
        axi_rsp.arready = state_reg.rd == RD_IDLE;
        axi_rsp.rvalid = state_reg.rd == RD_DATA;
        axi_rsp.rdata = state_reg.rdata;
        axi_rsp.rresp = state_reg.rresp;
        timebase.count = state_reg.count;
        timebase.count_down = state_reg.down;
        timebase.center_aligned = state_reg.cas; // [R07]
    end

    // Gate of two flops, so it drops the cycle either bit clears
    assign overflow_irq = state_reg.ovf && state_reg.ovie; // [R06] [R20]

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_up_wrap;
        step && !state_reg.cas && state_reg.count == top && !wr_cnt
            |=> state_reg.ovf && state_reg.count == 16'h0000;
    endproperty
    a_up_wrap: assert property (p_up_wrap) // [R01]
        else $error("up wrap did not set overflow");

    property p_center_turn;
        step && state_reg.cas && !state_reg.down && state_reg.count == top
            && !wr_cnt
            |=> state_reg.ovf && state_reg.down
            && state_reg.count == $past(state_reg.count) - 16'd1;
    endproperty
    a_center_turn: assert property (p_center_turn) // [R02]
        else $error("center turn did not set overflow");

    property p_clear_needs_arm;
        $fell(state_reg.ovf) |-> $past(state_reg.armed) && $past(wr_sc);
    endproperty
    a_clear_needs_arm: assert property (p_clear_needs_arm) // [R03]
        else $error("overflow flag cleared without armed read");

    property p_event_disarms;
        ovf_event |=> state_reg.ovf && !state_reg.armed;
    endproperty
    a_event_disarms: assert property (p_event_disarms) // [R04]
        else $error("overflow during clear sequence was lost");

    property p_write_one_keeps;
        wr_sc && wd[TCSC_BIT_OVF] && state_reg.ovf |=> state_reg.ovf;
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps) // [R05]
        else $error("writing one changed the flag");

    // Request moves only after an overflow or a status/control write
    property p_irq_level;
        $changed(overflow_irq) |-> $past(ovf_event) || $past(wr_sc);
    endproperty
    a_irq_level: assert property (p_irq_level) // [R06] [R20]
        else $error("interrupt level does not follow flag and enable");

    property p_bus_div1;
        state_reg.clk_sel == TCSC_CS_BUS && state_reg.ps == 3'd0
            && !debug_active && !state_reg.cas && !do_write
            && state_reg.count < top
            |=> state_reg.count == $past(state_reg.count) + 16'd1;
    endproperty
    a_bus_div1: assert property (p_bus_div1) // [R12]
        else $error("bus clock divide by one did not step");

    property p_off_holds;
        state_reg.clk_sel == TCSC_CS_OFF && !do_write
            |=> $stable(state_reg.count);
    endproperty
    a_off_holds: assert property (p_off_holds) // [R08]
        else $error("counter moved with no clock selected");

    property p_cnt_write;
        wr_cnt |=> state_reg.count == 16'h0000 && !state_reg.latched;
    endproperty
    a_cnt_write: assert property (p_cnt_write) // [R17] [R15]
        else $error("counter write did not reset counter and latch");

    property p_debug_freeze;
        debug_active && !do_write |=> $stable(state_reg.count)
            && $stable(state_reg.latched) && $stable(state_reg.hold);
    endproperty
    a_debug_freeze: assert property (p_debug_freeze) // [R19]
        else $error("debug mode did not freeze counter");

    property p_latch_frozen;
        state_reg.latched && !ar_hs && !do_write |=> $stable(state_reg.hold)
            && state_reg.latched;
    endproperty
    a_latch_frozen: assert property (p_latch_frozen) // [R14]
        else $error("latched counter value changed");

    c_up_wrap: cover property (ovf_event && !state_reg.cas);
    c_center_turn: cover property (ovf_event && state_reg.cas);
    c_clear_flag: cover property ($fell(state_reg.ovf));
    c_pair_read: cover property ($fell(state_reg.latched) && !do_write);

endmodule

// ---- tcsc_pkg.sv ----
// Package for the timer status/control and 16-bit counter block.
// Assumes a single bus clock domain and an AXI4-Lite master on 32-bit data.
package tcsc_pkg;

    // Register byte addresses, one aligned word each
    localparam logic [7:0] TCSC_OFF_SC = 8'h00;
    localparam logic [7:0] TCSC_OFF_CNTH = 8'h04;
    localparam logic [7:0] TCSC_OFF_CNTL = 8'h08;
    localparam logic [7:0] TCSC_OFF_MOD = 8'h0C;

    // Status/control field positions
    localparam int TCSC_BIT_OVF = 7;
    localparam int TCSC_BIT_OVIE = 6;
    localparam int TCSC_BIT_CAS = 5;
    localparam int TCSC_BIT_CSHI = 4;
    localparam int TCSC_BIT_CSLO = 3;
    localparam int TCSC_PS_MSB = 2;
    localparam int TCSC_PS_LSB = 0;

    // Reset values and counter limits
    localparam logic [7:0] TCSC_SC_RST = 8'h00;
    localparam logic [15:0] TCSC_CNT_RST = 16'h0000;
    localparam logic [15:0] TCSC_MOD_RST = 16'h0000;
    localparam logic [15:0] TCSC_CNT_TOP = 16'hFFFF;
    localparam logic [15:0] TCSC_CNT_ZERO = 16'h0000;

    // AXI responses
    localparam logic [1:0] TCSC_RESP_OKAY = 2'b00;
    localparam logic [1:0] TCSC_RESP_SLVERR = 2'b10;

    // Clock select codes
    localparam logic [1:0] TCSC_CS_OFF = 2'b00;
    localparam logic [1:0] TCSC_CS_BUS = 2'b01;
    localparam logic [1:0] TCSC_CS_FIXED = 2'b10;
    localparam logic [1:0] TCSC_CS_EXT = 2'b11;

    typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} tcsc_wr_t;
    typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_DATA = 2'b10} tcsc_rd_t;
    typedef enum logic [2:0] {
        SEL_NONE, SEL_SC, SEL_CNTH, SEL_CNTL, SEL_MOD
    } tcsc_sel_t;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } tcsc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcsc_axi_rsp_t;

    // View of the counter handed to the channels
    typedef struct packed {
        logic [15:0] count;
        logic count_down;
        logic center_aligned;
    } tcsc_timebase_t;

    typedef struct packed {
        logic ovf;
        logic ovie;
        logic cas;
        logic [1:0] clk_sel;
        logic [2:0] ps;
        logic armed;
        logic [15:0] count;
        logic down;
        logic [15:0] modulo;
        logic [6:0] pre;
        logic [1:0] fix_sync;
        logic fix_prev;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic latched;
        logic latch_hi;
        logic [15:0] hold;
        tcsc_wr_t wr;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] bresp;
        tcsc_rd_t rd;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } tcsc_state_t;

endpackage

// ---- tcsc_timer_tb.sv ----
// Self-checking bench for the timer status/control and counter block.
// Assumes the AXI4-Lite slave, counter and clock inputs of tcsc_timer.
`timescale 1ns/1ps
module tcsc_timer_tb
    import tcsc_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn;
    tcsc_axi_req_t axi_req;
    tcsc_axi_rsp_t axi_rsp;
    logic fixed_system_clock;
    logic external_timer_clock;
    logic debug_active;
    tcsc_timebase_t timebase;
    logic overflow_irq;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    int k;
    logic [31:0] rdat;
    logic [1:0] resp;
    logic [15:0] m;
    logic [15:0] c0;

    tcsc_timer i_dut (
        .aclk(aclk),
        .aresetn(aresetn),
        .axi_req(axi_req),
        .axi_rsp(axi_rsp),
        .fixed_system_clock(fixed_system_clock),
        .external_timer_clock(external_timer_clock),
        .debug_active(debug_active),
        .timebase(timebase),
        .overflow_irq(overflow_irq)
    );

    always #2.5 aclk = ~aclk;

    task automatic conclude;
        $display("Mismatches %0d, comparisons %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Ceiling well above the few thousand cycles the sequence needs
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t ns: run did not finish", $time);
            conclude();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] sc_val(input logic ie, input logic ca,
                                           input logic [1:0] cs,
                                           input logic [2:0] ps);
        sc_val = 32'h0;
        sc_val[TCSC_BIT_OVIE] = ie;
        sc_val[TCSC_BIT_CAS] = ca;
        sc_val[TCSC_BIT_CSHI:TCSC_BIT_CSLO] = cs;
        sc_val[TCSC_PS_MSB:TCSC_PS_LSB] = ps;
    endfunction

    // Handshakes are decided at the falling edge and acted on at the
    // following rising edge, so nothing races the slave's own update
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic aw_t;
        logic w_t;
        logic b_t;
        @(posedge aclk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.wstrb <= s;
        axi_req.bready <= 1'b1;
        b_t = 1'b0;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = axi_req.awvalid && axi_rsp.awready;
            w_t = axi_req.wvalid && axi_rsp.wready;
            b_t = axi_req.bready && axi_rsp.bvalid;
            @(posedge aclk);
            if (aw_t) axi_req.awvalid <= 1'b0;
            if (w_t) axi_req.wvalid <= 1'b0;
            if (b_t) begin
                resp = axi_rsp.bresp;
                axi_req.bready <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic ar_t;
        logic r_t;
        @(posedge aclk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        r_t = 1'b0;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = axi_req.arvalid && axi_rsp.arready;
            r_t = axi_req.rready && axi_rsp.rvalid;
            @(posedge aclk);
            if (ar_t) axi_req.arvalid <= 1'b0;
            if (r_t) begin
                rdat = axi_rsp.rdata;
                resp = axi_rsp.rresp;
                axi_req.rready <= 1'b0;
            end
        end
    endtask

    task automatic wait_cnt(input logic [15:0] v);
        int w;
        w = 0;
        while (timebase.count !== v && w < 3000) begin
            @(negedge aclk);
            w++;
        end
        chk(32'(w < 3000), 32'h1);
    endtask

    // Source period of four bus cycles, the fastest the far side may use
    // Only the bench drives the pin; no channel here contends for it
    task automatic pulses(input logic ext, input int cnt);
        repeat (cnt) begin
            @(posedge aclk);
            if (ext) external_timer_clock <= 1'b1;
            else fixed_system_clock <= 1'b1;
            repeat (2) @(posedge aclk);
            external_timer_clock <= 1'b0;
            fixed_system_clock <= 1'b0;
            @(posedge aclk);
        end
        repeat (6) @(posedge aclk);
    endtask

    initial begin
        axi_req = '0;
        aresetn = 1'b0;
        fixed_system_clock = 1'b0;
        external_timer_clock = 1'b0;
        debug_active = 1'b0;
        void'($urandom(41));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(TCSC_OFF_SC);
        chk(rdat, 32'h0);
        rd(TCSC_OFF_CNTH);
        chk(rdat, 32'h0);
        rd(TCSC_OFF_CNTL);
        chk(rdat, 32'h0);
        chk(32'(overflow_irq), 32'h0);
        rd(8'h40);
        chk(32'(resp), 32'(TCSC_RESP_SLVERR));
        wr(8'h40, $urandom, 4'hF);
        chk(32'(resp), 32'(TCSC_RESP_SLVERR));
        // Bus clock through every divisor; interval between two steps
        for (int p = 0; p < 8; p++) begin
            wr(TCSC_OFF_SC, sc_val(1'b0, 1'b0, TCSC_CS_BUS, 3'(p)), 4'h1);
            @(negedge aclk);
            c0 = timebase.count;
            while (timebase.count == c0) @(negedge aclk);
            c0 = timebase.count;
            k = 0;
            while (timebase.count == c0) begin
                @(negedge aclk);
                k++;
            end
            chk(32'(k), 32'(1 << p));
            chk(32'(timebase.count_down), 32'h0);
            chk(32'(timebase.center_aligned), 32'h0);
        end
        wr(TCSC_OFF_SC, sc_val(1'b0, 1'b0, TCSC_CS_OFF, 3'h0), 4'h1);
        @(negedge aclk);
        c0 = timebase.count;
        repeat (20) @(negedge aclk);
        chk(32'(timebase.count), 32'(c0));
        wr(TCSC_OFF_CNTH, $urandom, 4'hF);
        @(negedge aclk);
        chk(32'(timebase.count), 32'h0);
        // Fixed and pin sources; pulses on the other source must not count
        for (int s = 0; s < 2; s++) begin
            for (int p = 0; p < 2; p++) begin
                wr(TCSC_OFF_SC, sc_val(1'b0, 1'b0,
                   s ? TCSC_CS_EXT : TCSC_CS_FIXED, 3'(p)), 4'h1);
                wr(TCSC_OFF_CNTL, $urandom, 4'hF);
                n = $urandom_range(12, 4) * 2;
                pulses(s[0], n);
                pulses(!s[0], 4);
                chk(32'(timebase.count), 32'(n >> p));
            end
        end
        // Up-counting overflow against a random modulo
        m = 16'($urandom_range(40, 8));
        wr(TCSC_OFF_MOD, 32'(m), 4'h3);
        chk(32'(resp), 32'(TCSC_RESP_OKAY));
        rd(TCSC_OFF_MOD);
        chk(rdat, 32'(m));
        // Clear while stopped, so a stale count cannot wrap before the test
        wr(TCSC_OFF_CNTH, 32'h0, 4'hF);
        wr(TCSC_OFF_SC, sc_val(1'b1, 1'b0, TCSC_CS_BUS, 3'h0), 4'h1);
        wait_cnt(m);
        chk(32'(overflow_irq), 32'h0);
        @(negedge aclk);
        chk(32'(timebase.count), 32'h0);
        chk(32'(overflow_irq), 32'h1);
        wr(TCSC_OFF_SC, sc_val(1'b1, 1'b0, TCSC_CS_BUS, 3'h0), 4'h1);
        rd(TCSC_OFF_SC);
        chk(32'(rdat[7]), 32'h1);
        wr(TCSC_OFF_SC, sc_val(1'b1, 1'b0, TCSC_CS_OFF, 3'h0) | 32'h80,
           4'h1);
        rd(TCSC_OFF_SC);
        chk(rdat, 32'h0000_00C0);
        wr(TCSC_OFF_SC, sc_val(1'b1, 1'b0, TCSC_CS_OFF, 3'h0), 4'h1);
        rd(TCSC_OFF_SC);
        chk(rdat, 32'h0000_0040);
        chk(32'(overflow_irq), 32'h0);
        // Masked overflow, then a new overflow between arm and clear
        wr(TCSC_OFF_SC, sc_val(1'b0, 1'b0, TCSC_CS_BUS, 3'h0), 4'h1);
        wait_cnt(m);
        repeat (2) @(negedge aclk);
        chk(32'(overflow_irq), 32'h0);
        rd(TCSC_OFF_SC);
        chk(32'(rdat[7]), 32'h1);
        wait_cnt(m);
        @(negedge aclk);
        wr(TCSC_OFF_SC, sc_val(1'b1, 1'b0, TCSC_CS_OFF, 3'h0), 4'h1);
        rd(TCSC_OFF_SC);
        chk(rdat, 32'h0000_00C0);
        chk(32'(overflow_irq), 32'h1);
        // Center-aligned: flag on the step down from the top
        wr(TCSC_OFF_SC, sc_val(1'b1, 1'b1, TCSC_CS_OFF, 3'h0), 4'h1);
        chk(32'(overflow_irq), 32'h0);
        wr(TCSC_OFF_CNTH, 32'h0, 4'hF);
        wr(TCSC_OFF_SC, sc_val(1'b1, 1'b1, TCSC_CS_BUS, 3'h0), 4'h1);
        chk(32'(timebase.center_aligned), 32'h1);
        wait_cnt(m);
        chk(32'(overflow_irq), 32'h0);
        @(negedge aclk);
        chk(32'(timebase.count), 32'(m - 16'h1));
        chk(32'(timebase.count_down), 32'h1);
        chk(32'(overflow_irq), 32'h1);
        wait_cnt(16'h0);
        @(negedge aclk);
        chk(32'(timebase.count), 32'h1);
        chk(32'(timebase.count_down), 32'h0);
        // Coherent reads across a high-byte boundary
        wr(TCSC_OFF_SC, sc_val(1'b0, 1'b0, TCSC_CS_BUS, 3'h0), 4'h1);
        wr(TCSC_OFF_MOD, 32'h0, 4'h3);
        wr(TCSC_OFF_CNTH, 32'h0, 4'hF);
        wait_cnt(16'h00F0);
        rd(TCSC_OFF_CNTL);
        chk(32'(rdat[7:4]), 32'hF);
        repeat (150) @(posedge aclk);
        rd(TCSC_OFF_CNTH);
        chk(rdat, 32'h0);
        wait_cnt(16'h01F0);
        rd(TCSC_OFF_CNTH);
        chk(rdat, 32'h1);
        wr(TCSC_OFF_SC, sc_val(1'b0, 1'b0, TCSC_CS_BUS, 3'h0), 4'h1);
        repeat (150) @(posedge aclk);
        rd(TCSC_OFF_CNTL);
        chk(32'(rdat[7:4] != 4'hF), 32'h1);
        rd(TCSC_OFF_CNTH);
        chk(rdat, 32'h2);
        // Debug freeze, with a byte read while frozen
        @(posedge aclk);
        debug_active <= 1'b1;
        repeat (2) @(negedge aclk);
        c0 = timebase.count;
        rd(TCSC_OFF_CNTL);
        repeat (20) @(negedge aclk);
        chk(32'(timebase.count), 32'(c0));
        @(posedge aclk);
        debug_active <= 1'b0;
        repeat (5) @(negedge aclk);
        chk(32'(timebase.count != c0), 32'h1);
        // Second reset while the flag is still set
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        chk(32'(timebase.count), 32'h0);
        rd(TCSC_OFF_SC);
        chk(rdat, 32'h0);
        conclude();
    end
endmodule
